// File: src/pcm_audio_serial_port.sv
// Serial audio port with APB registers, master and slave framing.
// Behaviour
// - Primary mode: short sync, master or slave.
// - Auxiliary mode: long sync, master only.
// - Primary: sample on fall, drive on rise.
// - Primary: sync falling edge marks the MSB.
// - Primary: 256 to 2048 kHz at 8 kHz.
// - Primary: also 4096 kHz at 16 kHz.
// - Auxiliary: sample on fall, drive on rise.
// - Auxiliary: sync rising edge marks the MSB.
// - Auxiliary: 8 kHz half-duty sync, 256-2048 kHz.
// - Samples are 16-bit two's-complement linear.
// - Reset: master, short sync, 2048/8 kHz.
// - Data in/out fixed; clock, sync bidirectional.
//
// Design decisions made here: register access over APB and the placing of the registers.
`include "pcm_port_regs.svh"
`default_nettype none
module pcm_audio_serial_port (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link pins.
   input wire pcm_pkg::pcm_in_t pcm_i,
   output pcm_pkg::pcm_out_t pcm_o
);
   // Effective rate code: wide rate exists only in primary mode.
   function automatic logic [2:0] eff_rate(input pcm_pkg::ctrl_t c);
      if (c.rate > `PCM_RATE_WIDE || (c.aux && c.rate == `PCM_RATE_WIDE))
         return `PCM_RATE_TOP_NARROW;
      return c.rate;
   endfunction : eff_rate

   // Bit clock in kHz for a rate code.
   function automatic logic [12:0] bclk_khz(input logic [2:0] r);
      return 13'(`PCM_BCLK_BASE_KHZ << r);
   endfunction : bclk_khz

   // Bit slots per frame: bit clock over frame rate.
   function automatic logic [8:0] frame_slots(input logic [2:0] r);
      if (r == `PCM_RATE_WIDE)
         return 9'(bclk_khz(r) / `PCM_FS_WIDE_KHZ);
      return 9'(bclk_khz(r) / `PCM_FS_KHZ);
   endfunction : frame_slots

   // Divider step: two ticks per bit clock period.
   function automatic logic [`PCM_NCO_BITS-1:0] nco_step(
      input logic [2:0] r);
      logic [63:0] num;
      num = (64'(bclk_khz(r)) * 64'd2000) << `PCM_NCO_BITS;
      return `PCM_NCO_BITS'(num / 64'(`PCM_PCLK_HZ));
   endfunction : nco_step

   // One-hot register select; bit order CTRL, TXD, RXD, STAT.
   function automatic logic [3:0] reg_sel(input logic [7:0] a);
      return {a == `PCM_REG_STAT, a == `PCM_REG_RXD,
              a == `PCM_REG_TXD, a == `PCM_REG_CTRL};
   endfunction : reg_sel

   // Register state.
   pcm_pkg::ctrl_t ctrl_q, ctrl_d; // Mode and rate.
   logic [15:0] tx_data_q, tx_data_d; // Next sample to send.
   logic tx_pend_q, tx_pend_d; // Sample waits for a frame.
   logic [15:0] rx_data_q, rx_data_d; // Last received sample.
   logic rx_full_q, rx_full_d; // Unread sample held.
   logic ovr_q, ovr_d; // Unread sample lost to a new one.
   logic [31:0] prdata_d;
   logic pready_d, pslverr_d;
   logic first_q; // High in the first cycle after reset.

   // Link state.
   logic [2:0] s1_q, s2_q; // Synchronisers for bclk, sync, din.
   logic bclk_s3_q; // Previous synchronised bit clock.
   logic sync_f_q, sync_f_d; // Sync level at the last falling edge.
   logic [7:0] cnt_q, cnt_d; // Current bit slot in the frame.
   logic [15:0] tx_sh_q, tx_sh_d; // Outgoing shift register.
   logic [15:0] rx_sh_q, rx_sh_d; // Incoming shift register.
   logic bclk_q, bclk_d, sync_q, sync_d, dout_q, dout_d, oe_q, oe_d;

   // Decoded controls and events.
   logic master, tick, rise_ev, fall_ev, sync_lvl, din_s, resync;
   logic tx_take, rx_done, setup, acc;
   logic [2:0] rate;
   logic [8:0] slots;
   logic [7:0] cnt_nx;
   // Falling event delayed one cycle; din is captured then, because at
   // 4096 kHz the synchroniser lag can exceed the rise-to-fall spacing.
   logic cap_q, cap_d;
   logic ctrl_wr; // Control register written in this cycle.
   logic [15:0] rx_word, tx_word;
   logic [3:0] sel;

   // Two flip-flops on every incoming pin before any logic reads it.
   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
            end else begin
               s1_q[g] <= pcm_i[g];
               s2_q[g] <= s1_q[g];
            end
         end
      end
   endgenerate

   // Auxiliary mode forces master whatever the slave bit says.
   assign master = !ctrl_q.slave || ctrl_q.aux;
   assign rate = eff_rate(ctrl_q);
   assign slots = frame_slots(rate);

   pcm_bit_tick u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .step(nco_step(rate)),
      .tick(tick)
   );

   // Edge events come from the divider as master, from the pin as slave.
   always_comb begin
      din_s = s2_q[0];
      sync_lvl = master ? sync_q : s2_q[1];
      if (master) begin
         rise_ev = tick && !bclk_q;
         fall_ev = tick && bclk_q;
      end else begin
         rise_ev = s2_q[2] && !bclk_s3_q;
         fall_ev = !s2_q[2] && bclk_s3_q;
      end
      cnt_nx = (9'(cnt_q) >= slots - 9'd1) ? 8'h00 : cnt_q + 8'h01;
      // A slave realigns on the falling sync seen at a falling edge.
      resync = fall_ev && !master && !ctrl_q.aux && sync_f_q && !sync_lvl;
      rx_word = {rx_sh_q[14:0], din_s};
      tx_word = tx_pend_q ? tx_data_q : 16'h0000;
   end

   // Link next-state: counter, shifters, generated clock and sync.
   always_comb begin
      cnt_d = cnt_q;
      tx_sh_d = tx_sh_q;
      rx_sh_d = rx_sh_q;
      dout_d = dout_q;
      sync_d = sync_q;
      sync_f_d = sync_f_q;
      bclk_d = (master && tick) ? !bclk_q : bclk_q;
      oe_d = master;
      cap_d = fall_ev;
      tx_take = 1'b0;
      rx_done = 1'b0;
      if (rise_ev) begin
         cnt_d = cnt_nx;
         if (cnt_nx == 8'h00) begin
            // Frame start: load the sample and drive its MSB.
            tx_sh_d = tx_word;
            dout_d = tx_word[15];
            tx_take = 1'b1;
         end else if (cnt_nx < 8'(`PCM_SAMPLE_BITS)) begin
            tx_sh_d = {tx_sh_q[14:0], 1'b0};
            dout_d = tx_sh_q[14];
         end else begin
            dout_d = 1'b0; // Idle slots carry zero.
         end
         if (ctrl_q.aux)
            sync_d = 9'(cnt_nx) < (slots >> 1);
         else
            sync_d = 9'(cnt_nx) == slots - 9'd1;
      end
      if (fall_ev) begin
         sync_f_d = sync_lvl;
         if (resync)
            cnt_d = 8'h00;
      end
      // No rise follows a fall within one cycle, so cnt_q is still the
      // slot of the falling edge here.
      if (cap_q && cnt_q < 8'(`PCM_SAMPLE_BITS)) begin
         rx_sh_d = rx_word;
         rx_done = cnt_q == 8'(`PCM_SAMPLE_BITS - 1);
      end
      // A new mode or rate restarts framing at the next rising edge, so
      // no sync edge appears in the middle of a frame.
      if (ctrl_wr)
         cnt_d = 8'hFF;
   end

   // Link registers.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bclk_s3_q <= 1'b0;
         cap_q <= 1'b0;
         sync_f_q <= 1'b0;
         cnt_q <= 8'h00;
         tx_sh_q <= 16'h0000;
         rx_sh_q <= 16'h0000;
         bclk_q <= 1'b0;
         sync_q <= 1'b0;
         dout_q <= 1'b0;
         oe_q <= 1'b1;
      end else begin
         bclk_s3_q <= s2_q[2];
         cap_q <= cap_d;
         sync_f_q <= sync_f_d;
         cnt_q <= cnt_d;
         tx_sh_q <= tx_sh_d;
         rx_sh_q <= rx_sh_d;
         bclk_q <= bclk_d;
         sync_q <= sync_d;
         dout_q <= dout_d;
         oe_q <= oe_d;
      end
   end

   // Pins come straight from flip-flops; din is never driven.
   assign pcm_o = '{bclk: bclk_q, bclk_oe: oe_q, sync: sync_q,
                    sync_oe: oe_q, dout: dout_q};

   // APB: data is prepared in setup, so the access answers at once.
   always_comb begin
      setup = psel && !penable;
      acc = psel && penable && pready;
      sel = reg_sel(paddr);
      ctrl_wr = acc && pwrite && sel[0];
      pready_d = setup;
      pslverr_d = setup && (sel == 4'h0);
      prdata_d = 32'h0000_0000;
      if (setup && !pwrite) begin
         case (1'b1)
            sel[0]: prdata_d = {27'h0, ctrl_q};
            sel[1]: prdata_d = {16'h0000, tx_data_q};
            sel[2]: prdata_d = {16'h0000, rx_data_q};
            sel[3]: prdata_d = {29'h0, ovr_q, tx_pend_q, rx_full_q};
            default: prdata_d = 32'h0000_0000;
         endcase
      end
      ctrl_d = ctrl_q;
      tx_data_d = tx_data_q;
      rx_data_d = rx_data_q;
      tx_pend_d = tx_pend_q && !tx_take;
      rx_full_d = rx_full_q;
      ovr_d = ovr_q;
      if (ctrl_wr)
         ctrl_d = pcm_pkg::ctrl_t'(pwdata[`PCM_CTRL_MSB:`PCM_CTRL_LSB]);
      if (acc && pwrite && sel[1]) begin
         tx_data_d = pwdata[15:0];
         tx_pend_d = 1'b1; // A new write wins over a same-cycle take.
      end
      if (acc && !pwrite && sel[2])
         rx_full_d = 1'b0;
      if (acc && pwrite && sel[3] && pwdata[`PCM_STAT_OVR])
         ovr_d = 1'b0;
      // Hardware sets come last so they win over software clears.
      if (rx_done) begin
         rx_data_d = rx_word;
         rx_full_d = 1'b1;
         if (rx_full_q && !(acc && !pwrite && sel[2]))
            ovr_d = 1'b1;
      end
   end

   // Register file flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= pcm_pkg::ctrl_t'(`PCM_CTRL_RESET);
         tx_data_q <= 16'h0000;
         tx_pend_q <= 1'b0;
         rx_data_q <= 16'h0000;
         rx_full_q <= 1'b0;
         ovr_q <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         first_q <= 1'b1;
      end else begin
         ctrl_q <= ctrl_d;
         tx_data_q <= tx_data_d;
         tx_pend_q <= tx_pend_d;
         rx_data_q <= rx_data_d;
         rx_full_q <= rx_full_d;
         ovr_q <= ovr_d;
         prdata <= prdata_d;
         pready <= pready_d;
         pslverr <= pslverr_d;
         first_q <= 1'b0;
      end
   end

   // Checks on the link and register behaviour.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_frame_end;
      rise_ev && 9'(cnt_q) == slots - 9'd1;
   endsequence
   sequence s_aux_half;
      rise_ev && ctrl_q.aux && 9'(cnt_q) == (slots >> 1) - 9'd1;
   endsequence
   sequence s_last_bit;
      cap_q && cnt_q == 8'(`PCM_SAMPLE_BITS - 1);
   endsequence

   property p_reset_default;
      first_q |-> ctrl_q == pcm_pkg::ctrl_t'(`PCM_CTRL_RESET) && oe_q;
   endproperty
   a_reset_default: assert property (p_reset_default)
      else $error("Port did not come up as 2048 kHz short master.");
   property p_slave_release;
      ctrl_q.slave && !ctrl_q.aux |=> !pcm_o.bclk_oe && !pcm_o.sync_oe;
   endproperty
   a_slave_release: assert property (p_slave_release)
      else $error("Slave mode still drives clock or sync.");
   property p_aux_master;
      ctrl_q.aux |=> pcm_o.bclk_oe && pcm_o.sync_oe;
   endproperty
   a_aux_master: assert property (p_aux_master)
      else $error("Auxiliary mode is not driving clock and sync.");
   property p_dout_on_rise;
      $changed(pcm_o.dout) |-> $past(rise_ev);
   endproperty
   a_dout_on_rise: assert property (p_dout_on_rise)
      else $error("Data output changed away from a rising edge.");
   property p_capture_on_fall;
      $changed(rx_sh_q) |-> $past(fall_ev, 2);
   endproperty
   a_capture_on_fall: assert property (p_capture_on_fall)
      else $error("Input captured away from a falling edge.");
   property p_short_msb;
      master && !ctrl_q.aux && $fell(pcm_o.sync) |->
         cnt_q == 8'h00 && pcm_o.dout == tx_sh_q[15];
   endproperty
   a_short_msb: assert property (p_short_msb)
      else $error("Short sync fell away from the MSB slot.");
   property p_long_msb;
      ctrl_q.aux && $rose(pcm_o.sync) |-> cnt_q == 8'h00;
   endproperty
   a_long_msb: assert property (p_long_msb)
      else $error("Long sync rose away from the MSB slot.");
   property p_long_half;
      s_aux_half |=> !pcm_o.sync;
   endproperty
   a_long_half: assert property (p_long_half)
      else $error("Long sync did not fall at half frame.");
   property p_frame_len;
      s_frame_end |=> cnt_q == 8'h00;
   endproperty
   a_frame_len: assert property (p_frame_len)
      else $error("Frame did not wrap at its slot count.");
   property p_rx_word;
      s_last_bit |=> rx_full_q && rx_data_q == $past(rx_word);
   endproperty
   a_rx_word: assert property (p_rx_word)
      else $error("Received sample not stored after sixteen bits.");
   property p_tx_load;
      rise_ev && cnt_nx == 8'h00 |=> tx_sh_q == $past(tx_word);
   endproperty
   a_tx_load: assert property (p_tx_load)
      else $error("Sample not loaded at frame start.");
endmodule : pcm_audio_serial_port
`default_nettype wire

// File: src/pcm_bit_tick.sv
// Fractional divider that paces the generated bit clock.
`include "pcm_port_regs.svh"
`default_nettype none
module pcm_bit_tick (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Phase step per pclk cycle.
   input wire logic [`PCM_NCO_BITS-1:0] step,
   // One-cycle pulse at each half period of the bit clock.
   output logic tick
);
   logic [`PCM_NCO_BITS-1:0] acc_q; // Phase accumulator.
   logic [`PCM_NCO_BITS-1:0] acc_d;
   logic tick_d;
   logic [`PCM_NCO_BITS:0] sum;

   // The carry out marks a half period; rates that do not divide pclk
   // evenly jitter by one cycle, which the link tolerates.
   always_comb begin
      sum = {1'b0, acc_q} + {1'b0, step};
      acc_d = sum[`PCM_NCO_BITS-1:0];
      tick_d = sum[`PCM_NCO_BITS];
   end

   // Register the accumulator and the pulse.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= '0;
         tick <= 1'b0;
      end else begin
         acc_q <= acc_d;
         tick <= tick_d;
      end
   end
endmodule : pcm_bit_tick
`default_nettype wire

// File: src/pcm_pkg.sv
// Types shared by the serial audio port modules.
`default_nettype none
package pcm_pkg;
   // Control word: rate code, auxiliary mode, slave select.
   typedef struct packed {
      logic [2:0] rate;
      logic aux;
      logic slave;
   } ctrl_t;
   // Levels arriving on the link pins.
   typedef struct packed {
      logic bclk;
      logic sync;
      logic din;
   } pcm_in_t;
   // Levels and enables driven onto the link pins.
   typedef struct packed {
      logic bclk;
      logic bclk_oe;
      logic sync;
      logic sync_oe;
      logic dout;
   } pcm_out_t;
endpackage : pcm_pkg
`default_nettype wire

// File: src/pcm_port_regs.svh
// Register offsets, field positions, reset values and rate constants.
`ifndef PCM_PORT_REGS_SVH
`define PCM_PORT_REGS_SVH

// Register byte addresses on the APB bus.
`define PCM_REG_CTRL 8'h00
`define PCM_REG_TXD 8'h04
`define PCM_REG_RXD 8'h08
`define PCM_REG_STAT 8'h0C

// Control register fields and reset value (master, short sync, 2048 kHz).
`define PCM_CTRL_LSB 0
`define PCM_CTRL_MSB 4
`define PCM_CTRL_RESET 5'h0C

// Status register fields.
`define PCM_STAT_RXFULL 0
`define PCM_STAT_TXPEND 1
`define PCM_STAT_OVR 2

// Clock and rate figures.
`define PCM_PCLK_HZ 20000000
`define PCM_BCLK_BASE_KHZ 256
`define PCM_FS_KHZ 8
`define PCM_FS_WIDE_KHZ 16
`define PCM_RATE_WIDE 3'h4
`define PCM_RATE_TOP_NARROW 3'h3
`define PCM_SAMPLE_BITS 16
`define PCM_NCO_BITS 24

`endif

// File: testbench/pcm_codec_model.sv
// Behavioural audio codec that faces the serial audio port.
`default_nettype none
module pcm_codec_model (
   // Link pins as seen at the codec.
   input wire logic bclk,
   input wire logic sync,
   input wire logic dout,
   output logic din,
   // Clock and sync made here while the port is a slave.
   output logic bclk_o,
   output logic sync_o,
   // Set-up from the bench.
   input wire logic aux,
   input wire logic gen,
   input wire logic [8:0] slots,
   input wire logic [15:0] txw
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0; // Slot number, zero at the frame start.
   int hi = 0; // Slots with sync high in this frame.
   int last_len = 0; // Slots in the last whole frame.
   int last_hi = 0; // Sync-high slots in the last whole frame.
   int rx_n = 0; // Words received so far.
   int gcnt = 0; // Slot counter of the generated clock.
   int nx; // Slot that the next rising edge opens.
   logic det; // Frame start seen at this falling edge.
   logic sync_q = 1'b0; // Sync level at the previous falling edge.
   logic [15:0] sh = 16'h0000; // Receive shifter.
   logic [15:0] rx_word = 16'h0000; // Last word taken from the port.
   time t0 = 0; // Time of the last frame start.
   time per = 0; // Length of the last whole frame.

   // The generated clock stands still while the port is master.
   initial begin
      din = 1'b0;
      bclk_o = 1'b0;
      sync_o = 1'b0;
      #13;
      forever begin
         #200;
         if (gen) begin
            bclk_o = ~bclk_o;
            if (bclk_o) begin
               gcnt = (gcnt + 1) % int'(slots);
               sync_o = (gcnt == int'(slots) - 1);
            end
         end else begin
            bclk_o = 1'b0;
            sync_o = 1'b0;
         end
      end
   end

   // Data and sync are taken on the falling edge of the bit clock.
   always @(negedge bclk) begin
      det = aux ? (sync && !sync_q) : (!sync && sync_q);
      sync_q = sync;
      if (det) begin
         last_len = cnt + 1;
         last_hi = hi;
         per = $time - t0;
         t0 = $time;
         cnt = 0;
         hi = int'(sync);
      end else begin
         cnt = cnt + 1;
         hi = hi + int'(sync);
      end
      if (cnt < 16) sh = {sh[14:0], dout};
      if (cnt == 15) rx_word = sh;
      if (cnt == 16) rx_n = rx_n + 1;
   end

   // New data goes out on the rising edge; idle slots toggle so that
   // a port reading the wrong slot cannot match by chance.
   always @(posedge bclk) begin
      nx = (cnt + 1) % int'(slots);
      din <= (nx < 16) ? txw[15 - nx] : ~din;
   end
endmodule : pcm_codec_model
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the serial audio port with a codec model.
`include "pcm_port_regs.svh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // Clock, reset and APB master signals.
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   // Link pins and the codec's drivers.
   pcm_pkg::pcm_in_t pin_i;
   pcm_pkg::pcm_out_t pin_o;
   logic cdc_bclk;
   logic cdc_sync;
   logic cdc_din;
   // Codec set-up.
   logic [8:0] slots_v;
   logic aux_v;
   logic gen_v;
   logic [15:0] txw_v;
   // Counters and scratch results.
   int err_total = 0;
   int checks = 0;
   logic [31:0] rd;
   logic er;

   // A shared pin follows the port while its enable is high.
   assign pin_i = {pin_o.bclk_oe ? pin_o.bclk : cdc_bclk,
                   pin_o.sync_oe ? pin_o.sync : cdc_sync, cdc_din};

   pcm_audio_serial_port dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pcm_i(pin_i), .pcm_o(pin_o));

   pcm_codec_model cdc_u (.bclk(pin_i.bclk), .sync(pin_i.sync),
      .dout(pin_o.dout), .din(cdc_din), .bclk_o(cdc_bclk),
      .sync_o(cdc_sync), .aux(aux_v), .gen(gen_v), .slots(slots_v),
      .txw(txw_v));

   // The 20 MHz system clock.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb_xfer(input logic [7:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb_xfer

   // Sets a mode, exchanges one word each way and checks the framing.
   task automatic run_cfg(input logic [4:0] c, input int n,
      input int per_ns, input logic [15:0] tw);
      pcm_pkg::ctrl_t cf;
      int n0;
      logic oe;
      cf = c;
      oe = !(cf.slave && !cf.aux);
      @(posedge pclk);
      slots_v <= 9'(n);
      aux_v <= cf.aux;
      gen_v <= !oe;
      txw_v <= tw;
      apb_xfer(`PCM_REG_CTRL, 1'b1, {27'h0, c}, rd, er);
      n0 = cdc_u.rx_n;
      while (cdc_u.rx_n < n0 + 2) @(posedge pclk);
      // Loading mid-frame keeps the word out of the running frame.
      n0 = cdc_u.rx_n;
      apb_xfer(`PCM_REG_TXD, 1'b1, {16'h0, ~tw}, rd, er);
      while (cdc_u.rx_n < n0 + 1) @(posedge pclk);
      if (oe) chk({16'h0, cdc_u.rx_word}, {16'h0, ~tw});
      chk({30'h0, pin_o.bclk_oe, pin_o.sync_oe}, {30'h0, oe, oe});
      chk(cdc_u.last_len, n);
      chk(cdc_u.last_hi, cf.aux ? n / 2 : 1);
      chk({31'h0, (cdc_u.per > per_ns - 150) &&
         (cdc_u.per < per_ns + 150)}, 32'h1);
      apb_xfer(`PCM_REG_STAT, 1'b0, 32'h0, rd, er);
      chk(rd, 32'h00000005);
      apb_xfer(`PCM_REG_RXD, 1'b0, 32'h0, rd, er);
      chk(rd, {16'h0, tw});
      apb_xfer(`PCM_REG_STAT, 1'b1, 32'h00000004, rd, er);
      apb_xfer(`PCM_REG_STAT, 1'b0, 32'h0, rd, er);
      chk(rd, 32'h00000000);
      $display("test ctrl=%h done", c);
   endtask : run_cfg

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // Main sequence: reset, refused access, every mode and rate.
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slots_v = 9'h100;
      aux_v = 1'b0;
      gen_v = 1'b0;
      txw_v = 16'h0000;
      repeat (16) @(posedge pclk);
      chk({27'h0, pin_o}, 32'h0000000A);
      presetn <= 1'b1;
      apb_xfer(8'h10, 1'b1, 32'hFFFFFFFF, rd, er);
      chk({31'h0, er}, 32'h00000001);
      apb_xfer(`PCM_REG_CTRL, 1'b0, 32'h0, rd, er);
      chk(rd, 32'h0000000C);
      $display("test reset done");
      for (int r = 0; r < 5; r++) begin
         run_cfg({r[2:0], 2'b00}, (r == 4) ? 256 : 32 << r,
            (r == 4) ? 62500 : 125000, 16'h8000 + 16'(r));
      end
      // The slave bit is set too: auxiliary mode must stay master.
      for (int r = 0; r < 4; r++) begin
         run_cfg({r[2:0], 2'b11}, 32 << r, 125000,
            16'h7FF0 + 16'(r));
      end
      run_cfg(5'h01, 32, 12800, 16'h1234);
      print_verdict();
   end

   // Cuts a hang short well after the expected run length.
   initial begin
      repeat (90000) @(posedge pclk);
      err_total++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
